// ==== design/sdf_pkg.sv ====
package sdf_pkg;

    // ------------------------------------------------------------------
    // Widths and fixed figures
    // ------------------------------------------------------------------
    localparam int MOD_DIV = 8;                // Converter clocks per modulator bit.
    localparam logic [2:0] MOD_DIV_LAST = 3'h7;
    localparam int S1_ORDER = 5;               // Fixed order of the first stage.
    localparam int S2_ORDER_MAX = 4;           // Highest order of the second stage.
    localparam int S1_W = 32;                  // 2 bits for the +1/-1 input plus 5 * log2(64) growth.
    localparam int S2_W = 84;                  // S1_W plus 4 * 13 bits for ratios up to 5760.
    localparam int FIR_W = S2_W + 5;           // Room for a sum of 30 words.
    localparam int OUT_W = FIR_W + 3;          // Room for an average of up to 8 words.
    localparam int A_W = 7;
    localparam int B_W = 13;
    localparam int AVG_W = 4;
    localparam logic [A_W-1:0] A_FULL = 7'h40; // Ratio 64, the only one feeding stage two.
    localparam logic [4:0] FIR_LAST = 5'h1d;   // FIR decimation by 30.
    localparam logic [B_W-1:0] FIR_PRE_B = 13'h0018; // 64 * 24 gives 600 Hz.
    localparam logic [3:0] BYPASS_MIN_CODE = 4'hd;    // Codes 1101 and up skip stage two.
    localparam int FIR_SEL_BIT = 2;            // Order field values 1xx select FIR.

    // Configuration carried as one word.
    typedef struct packed {
        logic fir;
        logic [1:0] order;   // 0..3 means sinc1..sinc4.
        logic [3:0] rate;
    } cfg_s;

    // First-stage ratio from the rate code.
    function automatic logic [A_W-1:0] s1_ratio(input cfg_s c);
        if (c.fir) begin
            s1_ratio = A_FULL;
        end else if (c.rate == 4'hf) begin
            s1_ratio = 7'h18;
        end else if (c.rate == 4'he) begin
            s1_ratio = 7'h30;
        end else begin
            s1_ratio = A_FULL;
        end
    endfunction

    // Second-stage ratio from the rate code.
    function automatic logic [B_W-1:0] s2_ratio(input cfg_s c);
        if (c.fir) begin
            s2_ratio = FIR_PRE_B;
        end else begin
            case (c.rate)
                4'h0: s2_ratio = 13'h1680;
                4'h1: s2_ratio = 13'h0b40;
                4'h2: s2_ratio = 13'h05a0;
                4'h3: s2_ratio = 13'h0360;
                4'h4: s2_ratio = 13'h02d0;
                4'h5: s2_ratio = 13'h0120;
                4'h6: s2_ratio = 13'h00f0;
                4'h7: s2_ratio = 13'h0090;
                4'h8: s2_ratio = 13'h0024;
                4'h9: s2_ratio = 13'h000c;
                4'ha: s2_ratio = 13'h0006;
                4'hb: s2_ratio = 13'h0003;
                4'hc: s2_ratio = 13'h0002;
                default: s2_ratio = 13'h0001;
            endcase
        end
    endfunction

    // Averager ratio after the FIR: 20, 10, 5 and 2.5 words per second.
    function automatic logic [AVG_W-1:0] avg_ratio(input cfg_s c);
        case (c.rate)
            4'h0: avg_ratio = 4'h8;
            4'h1: avg_ratio = 4'h4;
            4'h2: avg_ratio = 4'h2;
            default: avg_ratio = 4'h1;
        endcase
    endfunction

endpackage

// ==== design/sigma_delta_decimation_filter.sv ====
`timescale 1ns/1ps
// Behaviour
// - Stage one is a fixed fifth-order sinc decimator fed by the modulator bit taken every eighth clock.
// - Stage one decimates by 24, 48 or 64.
// - Rate codes for 38400, 19200 and 14400 words per second deliver stage-one words and skip stage two.
// - Stage two takes stage-one words only at ratio 64 and decimates them further.
// - Outside FIR mode, output words come every 8 * A * B clocks, A and B being the two stage ratios.
// - A three-bit order field of the first mode register selects the stage-two order.
// - Stage two runs as sinc1, sinc2, sinc3 or sinc4.
// - A four-bit rate code of the second mode register selects the output rate.
// - Codes 0000 to 0110 use A = 64 with B = 5760, 2880, 1440, 864, 720, 288 and 240.
// - Codes 0111 to 1101 use A = 64 with B = 144, 36, 12, 6, 3, 2, 1; 1110 uses 48 and 1111 uses 24.
// - All rates follow the converter clock, since every ratio counts clock cycles.
// - FIR mode gives 20, 10, 5 and 2.5 words per second, each settled in one conversion.
// - The FIR section takes stage-two words at 600 Hz and decimates by 30.
// - For 10, 5 and 2.5 words per second a first-order averager follows the FIR.
// - A higher stage-two order adds comb sections and so lengthens the settling of a result.
module sigma_delta_decimation_filter
    import sdf_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic mod_bit_in,
    input wire logic [2:0] order_in,
    input wire logic [3:0] rate_code_in,
    output logic [OUT_W-1:0] sample_out,
    output logic sample_valid_out
);

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    cfg_s cfg;
    cfg_s cfg_q;
    logic cfg_chg;
    logic [A_W-1:0] ratio_a;
    logic [B_W-1:0] ratio_b;
    logic [AVG_W-1:0] ratio_avg;
    logic bypass;

    // Order field and rate code form one word; a change restarts every counter except the modulator bit divider.
    assign cfg = '{fir: order_in[FIR_SEL_BIT], order: order_in[1:0], rate: rate_code_in};
    assign ratio_a = s1_ratio(cfg);
    assign ratio_b = s2_ratio(cfg);
    assign ratio_avg = avg_ratio(cfg);
    assign bypass = !cfg.fir && (cfg.rate >= BYPASS_MIN_CODE);
    assign cfg_chg = (cfg != cfg_q);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg;
        end
    end

    // ------------------------------------------------------------------
    // Modulator bit rate
    // ------------------------------------------------------------------
    logic [2:0] mod_div;
    logic mod_en;

    // The modulator delivers one bit every eighth clock, so all rates follow the clock.
    assign mod_en = (mod_div == MOD_DIV_LAST);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mod_div <= '0;
        end else begin
            mod_div <= mod_div + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Stage one: sinc5 integrators, decimator and combs
    // ------------------------------------------------------------------
    logic signed [S1_W-1:0] i1_n [0:S1_ORDER];
    logic signed [S1_W-1:0] i1_q [1:S1_ORDER];
    logic signed [S1_W-1:0] c1_n [0:S1_ORDER];
    logic signed [S1_W-1:0] c1_d [1:S1_ORDER];
    logic [A_W-1:0] s1_cnt;
    logic s1_tick;
    logic signed [S1_W-1:0] s1_data;
    logic s1_valid;

    // A one maps to +1 and a zero to -1, so the word stays centred on zero.
    assign i1_n[0] = mod_bit_in ? S1_W'(1) : -S1_W'(1);
    assign c1_n[0] = i1_n[S1_ORDER];
    assign s1_tick = mod_en && (s1_cnt == ratio_a - A_W'(1));

    // Wrapping sums are intended: the combs undo any overflow of the integrators.
    for (genvar k = 1; k <= S1_ORDER; k++) begin : g_s1
        assign i1_n[k] = i1_q[k];
        assign c1_n[k] = c1_n[k-1] - c1_d[k];
        always_ff @(posedge sys_clk_in) begin
            if (rst_in) begin
                i1_q[k] <= '0;
                c1_d[k] <= '0;
            end else begin
                if (mod_en) begin
                    i1_q[k] <= i1_q[k] + i1_n[k-1];
                end
                if (s1_tick) begin
                    c1_d[k] <= c1_n[k-1];
                end
            end
        end
    end

    // Decimation counter and stage-one word.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cfg_chg) begin
            s1_cnt <= '0;
            s1_valid <= 1'b0;
            s1_data <= '0;
        end else begin
            s1_valid <= s1_tick;
            if (s1_tick) begin
                s1_cnt <= '0;
                s1_data <= c1_n[S1_ORDER];
            end else if (mod_en) begin
                s1_cnt <= s1_cnt + A_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Stage two: sinc1 to sinc4 with variable ratio
    // ------------------------------------------------------------------
    logic s2_in_en;
    logic [1:0] s2_order;
    logic signed [S2_W-1:0] i2_n [0:S2_ORDER_MAX];
    logic signed [S2_W-1:0] i2_q [1:S2_ORDER_MAX];
    logic signed [S2_W-1:0] c2_n [0:S2_ORDER_MAX];
    logic signed [S2_W-1:0] c2_d [1:S2_ORDER_MAX];
    logic [B_W-1:0] s2_cnt;
    logic s2_tick;
    logic signed [S2_W-1:0] s2_data;
    logic s2_valid;

    // Only ratio-64 words reach stage two; the FIR pre-stage runs as sinc1.
    assign s2_in_en = s1_valid && !bypass && (ratio_a == A_FULL);
    assign s2_order = cfg.fir ? 2'h0 : cfg.order;
    assign i2_n[0] = S2_W'(s1_data);
    assign c2_n[0] = i2_n[32'(s2_order) + 1];
    assign s2_tick = s2_in_en && (s2_cnt == ratio_b - B_W'(1));

    // Comb sections beyond the selected order pass their input through unchanged.
    for (genvar k = 1; k <= S2_ORDER_MAX; k++) begin : g_s2
        assign i2_n[k] = i2_q[k];
        assign c2_n[k] = (k <= 32'(s2_order) + 1) ? c2_n[k-1] - c2_d[k] : c2_n[k-1];
        always_ff @(posedge sys_clk_in) begin
            if (rst_in) begin
                i2_q[k] <= '0;
                c2_d[k] <= '0;
            end else begin
                if (s2_in_en) begin
                    i2_q[k] <= i2_q[k] + i2_n[k-1];
                end
                if (s2_tick) begin
                    c2_d[k] <= c2_n[k-1];
                end
            end
        end
    end

    // Stage-two decimation counter and word.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cfg_chg) begin
            s2_cnt <= '0;
            s2_valid <= 1'b0;
            s2_data <= '0;
        end else begin
            s2_valid <= s2_tick;
            if (s2_tick) begin
                s2_cnt <= '0;
                s2_data <= c2_n[S2_ORDER_MAX];
            end else if (s2_in_en) begin
                s2_cnt <= s2_cnt + B_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // FIR section and averager
    // ------------------------------------------------------------------
    logic fir_en;
    logic [4:0] fir_cnt;
    logic fir_tick;
    logic signed [FIR_W-1:0] fir_acc;
    logic signed [FIR_W-1:0] fir_sum;
    logic signed [FIR_W-1:0] fir_data;
    logic fir_valid;
    logic [AVG_W-1:0] avg_cnt;
    logic avg_tick;
    logic signed [OUT_W-1:0] avg_acc;
    logic signed [OUT_W-1:0] avg_sum;
    logic signed [OUT_W-1:0] avg_data;
    logic avg_valid;

    // Each FIR word spans exactly its own 30 inputs, so it is settled at once.
    assign fir_en = s2_valid && cfg.fir;
    assign fir_tick = fir_en && (fir_cnt == FIR_LAST);
    assign fir_sum = fir_acc + FIR_W'(s2_data);
    assign avg_tick = fir_valid && (avg_cnt == ratio_avg - AVG_W'(1));
    assign avg_sum = avg_acc + OUT_W'(fir_data);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cfg_chg) begin
            fir_cnt <= '0;
            fir_acc <= '0;
            fir_data <= '0;
            fir_valid <= 1'b0;
        end else begin
            fir_valid <= fir_tick;
            if (fir_tick) begin
                fir_cnt <= '0;
                fir_acc <= '0;
                fir_data <= fir_sum;
            end else if (fir_en) begin
                fir_cnt <= fir_cnt + 5'h01;
                fir_acc <= fir_sum;
            end
        end
    end

    // The averager is a plain block sum; ratio one passes each FIR word.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cfg_chg) begin
            avg_cnt <= '0;
            avg_acc <= '0;
            avg_data <= '0;
            avg_valid <= 1'b0;
        end else begin
            avg_valid <= avg_tick;
            if (avg_tick) begin
                avg_cnt <= '0;
                avg_acc <= '0;
                avg_data <= avg_sum;
            end else if (fir_valid) begin
                avg_cnt <= avg_cnt + AVG_W'(1);
                avg_acc <= avg_sum;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    // One source is live per configuration, so the priority never arbitrates two words.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cfg_chg) begin
            sample_out <= '0;
            sample_valid_out <= 1'b0;
        end else begin
            sample_valid_out <= 1'b0;
            if (bypass && s1_valid) begin
                sample_out <= OUT_W'(s1_data);
                sample_valid_out <= 1'b1;
            end else if (!bypass && !cfg.fir && s2_valid) begin
                sample_out <= OUT_W'(s2_data);
                sample_valid_out <= 1'b1;
            end else if (cfg.fir && avg_valid) begin
                sample_out <= avg_data;
                sample_valid_out <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] out_gap;
    logic [31:0] exp_gap;
    logic out_armed;
    logic [9:0] s1_gap;
    logic s1_armed;

    assign exp_gap = 32'(MOD_DIV) * 32'(ratio_a) * 32'(ratio_b) * (cfg.fir ? 32'(30) * 32'(ratio_avg) : 32'(1));

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || cfg_chg) begin
            out_gap <= '0;
            out_armed <= 1'b0;
            s1_gap <= '0;
            s1_armed <= 1'b0;
        end else begin
            out_gap <= sample_valid_out ? 32'(1) : out_gap + 32'(1);
            out_armed <= out_armed || sample_valid_out;
            s1_gap <= s1_valid ? 10'(1) : s1_gap + 10'(1);
            s1_armed <= s1_armed || s1_valid;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_mod_bit_period: assert property (mod_en |=> !mod_en [*7] ##1 mod_en)
        else $error("modulator enable not every eighth clock");
    // Words already in flight when the configuration moves belong to the old setting, so that cycle and the next are excluded.
    a_s1_word_gap: assert property (s1_valid && s1_armed && !cfg_chg && !$past(cfg_chg) |-> s1_gap == 10'(MOD_DIV) * 10'(ratio_a))
        else $error("stage one word spacing wrong");
    a_bypass_source: assert property (sample_valid_out && bypass && !cfg_chg |-> $past(s1_valid) && sample_out == OUT_W'($past(s1_data)))
        else $error("bypass word not from stage one");
    a_s2_feed_ratio: assert property (s2_valid && !cfg_chg |-> ratio_a == A_FULL && !bypass)
        else $error("stage two fed at wrong ratio");
    a_out_word_gap: assert property (sample_valid_out && out_armed && !cfg_chg |-> out_gap == exp_gap)
        else $error("output spacing differs from 8*A*B");
    a_order_select: assert property (!cfg.fir |-> s2_order == order_in[1:0])
        else $error("order field not applied");
    a_fir_prestage: assert property (order_in[FIR_SEL_BIT] |-> ratio_a == A_FULL && ratio_b == FIR_PRE_B)
        else $error("FIR pre-stage ratios wrong");
    a_fast_ratio: assert property (!order_in[FIR_SEL_BIT] && rate_code_in == 4'hf |-> ratio_a == 7'h18)
        else $error("code 1111 not at ratio 24");
    a_fir_count: assert property (fir_valid |-> $past(fir_en) && $past(fir_cnt) == FIR_LAST)
        else $error("FIR word not after 30 inputs");
    a_valid_pulse: assert property (sample_valid_out |=> !sample_valid_out)
        else $error("valid strobe longer than one cycle");

    c_bypass_out: cover property (sample_valid_out && bypass);
    c_sinc4_out: cover property (sample_valid_out && !cfg.fir && cfg.order == 2'h3);
    c_fir_out: cover property (sample_valid_out && cfg.fir && ratio_avg == 4'h2);

endmodule

// ==== verification/mod_stream_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Modulator bit stream seen by the decimation filter
// ----------------------------------------------------------------------
module mod_stream_model (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic rand_mode_in,
    input wire logic rand_in,
    output logic mod_bit_out
);
    logic [2:0] phase = 3'h0;
    logic bit_q = 1'b1;

    // The bit period is eight converter clocks, phased from the release of reset.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            phase <= 3'h0;
        end else begin
            phase <= phase + 3'h1;
        end
    end

    // A new bit is launched on the sampling edge itself, so it stands a whole period.
    // A constant stream of ones gives a known settled word; the random stream stresses the bounds.
    always @(posedge sys_clk_in) begin
        if (rst_in || phase == 3'h7) begin
            bit_q <= rand_mode_in ? rand_in : 1'b1;
        end
    end

    assign mod_bit_out = bit_q;
endmodule

// ==== verification/sigma_delta_decimation_filter_tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Self-checking bench for the decimation filter
// ----------------------------------------------------------------------
module sigma_delta_decimation_filter_tb;
    import sdf_pkg::*;

    localparam int b_tab [16] = '{5760, 2880, 1440, 864, 720, 288, 240, 144, 36, 12, 6, 3, 2, 1, 1, 1};

    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic mod_bit;
    logic [2:0] order_in = 3'h0;
    logic [3:0] rate_code_in = 4'hf;
    logic rand_mode = 1'b0;
    logic rnd = 1'b0;
    logic [31:0] lfsr_state = 32'hfb8d;
    logic [OUT_W-1:0] sample_out;
    logic sample_valid_out;
    logic prev_valid = 1'b0;
    logic [OUT_W-1:0] last_word = '0;
    int error_cnt = 0;
    int n_checks = 0;
    int gap = 0;
    int last_gap = 0;
    int words = 0;

    always #2 sys_clk_in = ~sys_clk_in;

    sigma_delta_decimation_filter sigma_delta_decimation_filter_inst (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .mod_bit_in(mod_bit),
        .order_in(order_in),
        .rate_code_in(rate_code_in),
        .sample_out(sample_out),
        .sample_valid_out(sample_valid_out)
    );

    mod_stream_model mod_stream_model_inst (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .rand_mode_in(rand_mode),
        .rand_in(rnd),
        .mod_bit_out(mod_bit)
    );

    // ------------------------------------------------------------------
    // Expectations and helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic longint a_of(input int c);
        return (c == 15) ? 64'd24 : ((c == 14) ? 64'd48 : 64'd64);
    endfunction

    function automatic logic [OUT_W-1:0] exp_gap(input int c);
        return OUT_W'(8 * a_of(c) * b_tab[c]);
    endfunction

    // An all-ones stream settles to A^5, times B^N when stage two is in the path.
    function automatic logic [OUT_W-1:0] exp_word(input int c, input int o);
        longint v;
        v = a_of(c) ** 5;
        if (c < 13) begin
            for (int i = 0; i <= o; i++) begin
                v = v * b_tab[c];
            end
        end
        return OUT_W'(v);
    endfunction

    task automatic check(input string name, input logic [OUT_W-1:0] exp, input logic [OUT_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Applies a configuration and waits for n further words under a bounded count.
    task automatic apply(input logic [2:0] ord, input logic [3:0] code, input logic rm, input int n);
        int target;
        int t;
        @(posedge sys_clk_in);
        order_in <= ord;
        rate_code_in <= code;
        rand_mode <= rm;
        target = words + n;
        t = 0;
        while (words < target && t < 60000) begin
            @(posedge sys_clk_in);
            t++;
        end
        if (words < target) begin
            error_cnt++;
            $display("[FAIL] word_count expected %0d seen %0d", target, words);
        end
    endtask

    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Monitor: word spacing, last word and strobe width
    // ------------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        rnd <= lfsr_state[0];
        lfsr_state <= lfsr_next(lfsr_state);
        if (sample_valid_out === 1'b1) begin
            check("valid_width", '0, OUT_W'(prev_valid));
        end
        prev_valid <= sample_valid_out;
        if (rst_in) begin
            gap = 0;
            words = 0;
        end else begin
            gap = gap + 1;
            if (sample_valid_out === 1'b1) begin
                last_gap = gap;
                gap = 0;
                words = words + 1;
                last_word = sample_out;
            end
        end
    end

    // Random stream and configuration; a settled word can never exceed the all-ones value.
    task automatic rand_case();
        int c;
        int o;
        logic signed [OUT_W-1:0] sw;
        logic [OUT_W-1:0] mag;
        c = 11 + int'(lfsr_state % 5);
        o = int'(lfsr_state[9:8]);
        apply(3'(o), 4'(c), 1'b1, 10);
        sw = last_word;
        mag = (sw < 0) ? -sw : sw;
        check("rand_gap", exp_gap(c), OUT_W'(last_gap));
        check("rand_bound", OUT_W'(1), OUT_W'(mag <= exp_word(c, o)));
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int w0;
        repeat (8) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // Bypass codes, where only the first stage sets rate and gain.
        for (int c = 13; c < 16; c++) begin
            apply(3'h3, 4'(c), 1'b0, 9);
            check("bypass_gap", exp_gap(c), OUT_W'(last_gap));
            check("bypass_word", exp_word(c, 3), last_word);
        end
        // Every stage-two order at the shortest stage-two ratio.
        for (int o = 0; o < 4; o++) begin
            apply(3'(o), 4'hc, 1'b0, 10);
            check("sinc_gap", exp_gap(12), OUT_W'(last_gap));
            check("sinc_word", exp_word(12, o), last_word);
        end
        apply(3'h0, 4'h9, 1'b0, 4);
        check("ratio12_gap", exp_gap(9), OUT_W'(last_gap));
        check("ratio12_word", exp_word(9, 0), last_word);
        rand_case();
        // FIR words at code 1111 take 368640 clocks each, so none may appear in a short window.
        apply(3'h4, 4'hf, 1'b0, 0);
        // A word of the old setting may still leave in the edge of the change, so count from two edges later.
        repeat (2) @(posedge sys_clk_in);
        w0 = words;
        repeat (4000) @(posedge sys_clk_in);
        check("fir_quiet", OUT_W'(w0), OUT_W'(words));
        // A second reset in mid-run clears the output and the strobe.
        apply(3'h0, 4'hf, 1'b0, 3);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        check("reset_word", '0, sample_out);
        check("reset_valid", '0, OUT_W'(sample_valid_out));
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        apply(3'h0, 4'hf, 1'b0, 9);
        check("rerun_gap", exp_gap(15), OUT_W'(last_gap));
        stop_test();
    end

    // The sequence needs about 90,000 cycles; the limit allows some 120,000.
    initial begin
        #480000;
        error_cnt++;
        $display("[FAIL] run_time expected finish seen timeout");
        stop_test();
    end
endmodule
